// File: rtl/aod_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module aod_debounce (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   reset_n,
  // filter channel
  aod_flt_if.filt     f
);
  logic [7:0] cnt_reg;
  logic       flag_reg;
  logic [7:0] lim;

  assign lim    = flag_reg ? f.dn_ms : f.up_ms;
  assign f.flag = flag_reg;

  // lim+1 ticks are needed, so the held time is never shorter than lim ms
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_reg  <= 8'h00;
      flag_reg <= 1'b0;
    end
    else if (f.raw == flag_reg)
      cnt_reg <= 8'h00;
    else if (f.tick)
    begin
      if (cnt_reg >= lim)
      begin
        flag_reg <= f.raw;
        cnt_reg  <= 8'h00;
      end
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: rtl/aod_flt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface aod_flt_if;
  logic       tick;
  logic       raw;
  logic [7:0] up_ms;
  logic [7:0] dn_ms;
  logic       flag;
  modport filt (input tick, input raw, input up_ms, input dn_ms, output flag);
  modport ctl  (output tick, output raw, output up_ms, output dn_ms, input flag);
endinterface
`default_nettype wire

// File: rtl/aod_pkg.sv
`default_nettype none
package aod_pkg;
  // register map, byte addressed over the register write/read commands
  localparam logic [7:0] A_GAIN    = 8'h00;
  localparam logic [7:0] A_LOCK    = 8'h01;
  localparam logic [7:0] A_DIAG    = 8'h02;
  localparam logic [7:0] A_SPAN    = 8'h03;
  localparam logic [7:0] A_MASK    = 8'h04;
  localparam logic [7:0] A_GMIN    = 8'h05;
  localparam logic [7:0] A_GMAX    = 8'h06;
  localparam logic [7:0] A_TMIN    = 8'h07;
  localparam logic [7:0] A_TMAX    = 8'h08;
  localparam logic [7:0] A_FMIN    = 8'h09;
  localparam logic [7:0] A_FMAX    = 8'h0a;
  localparam logic [7:0] A_ZWP     = 8'h0b;
  localparam logic [7:0] A_CLO     = 8'h0d;
  localparam logic [7:0] A_CHI     = 8'h0f;
  localparam logic [7:0] A_WRG     = 8'h11;
  localparam logic [7:0] A_FTRACE  = 8'h14;
  localparam logic [7:0] A_UTAG    = 8'h18;
  localparam logic [7:0] A_PX      = 8'h20;
  localparam logic [7:0] A_PY      = 8'h40;
  localparam logic [7:0] A_SLOPE   = 8'h70;
  localparam logic [7:0] A_DY      = 8'h80;
  localparam logic [7:0] A_STATUS  = 8'ha0;
  localparam logic [7:0] A_GUSE    = 8'ha1;
  // field positions
  localparam int B_AGC   = 7;
  localparam int B_LOCK  = 7;
  localparam int B_DDIS  = 0;
  localparam int B_FSEL  = 1;
  localparam int B_LNR   = 4;
  localparam int B_ROT   = 6;
  localparam logic [6:0] LOCK_KEY = 7'h3a;
  // timing: 1 ms prescale, debounce times in ms indexed by select code
  localparam int CLK_MHZ   = 250;
  localparam int MS_US     = 1000;
  localparam int MS_CYCLES = CLK_MHZ * MS_US;
  localparam logic [63:0] UP_MS = 64'h7864_503c_2814_1414;
  localparam logic [63:0] DN_MS = 64'h8c78_6450_2828_1e14;
  // 32-point offsets: code 0 moves a point by 2048 of 65536, i.e. offset<<4
  localparam int DY_SHIFT = 4;
  localparam logic [16:0] MID_ANGLE = 17'h08000;
  typedef enum logic [1:0] {LNR_4PT, LNR_8PT, LNR_16PT, LNR_32PT} aod_lnr_t;

  function automatic logic [7:0] cfg_reset(input logic [7:0] a);
    case (a)
      A_GAIN:   cfg_reset = 8'h81;
      A_DIAG:   cfg_reset = 8'h31;
      A_SPAN:   cfg_reset = 8'h03;
      A_MASK:   cfg_reset = 8'h80;
      A_GMAX:   cfg_reset = 8'h1f;
      A_TMAX:   cfg_reset = 8'h7f;
      A_FMAX:   cfg_reset = 8'hff;
      A_CHI:    cfg_reset = 8'hff;
      A_CHI+1:  cfg_reset = 8'hff;
      A_WRG:    cfg_reset = 8'hff;
      A_WRG+1:  cfg_reset = 8'hff;
      default:  cfg_reset = 8'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: rtl/aod_top.sv
// Overview of operation
// - auto gain set uses the tracking gain, clear uses the programmed gain code
// - four fixed factory trace bytes and four writable user tag bytes, full byte range
// - lock bit counts only while the 7-bit lock code equals 0x3a
// - effective lock makes storage read-only; writes are refused
// - diagnostics run when the disable bit is 0, suspended when 1
// - 8-bit suppress mask: crc, gain, current, vdig, cordic, field, adc, temp
// - gain setting compared against 5-bit low and high limits
// - temperature compared against 7-bit low and high limits
// - field strength compared against 8-bit low and high limits
// - 3-bit select picks step-up and step-down debounce times in ms
// - all angles referenced to one programmable zero and wrap point
// - rotation sense 0 counts up counterclockwise, 1 counts up clockwise
// - output limited between low and high clamp in every curve mode
// - four-point mode: five segments, user X, signed Y and user slopes
// - eight-point mode starts at 0,0 and derives slopes from neighbours
// - sixteen-point mode: equal X spacing, Y from -50% to +150%, clamped
// - thirty-two-point mode: 32 segments around 180, signed offsets on ideal line
// - 2-bit span code scales offsets to 3.125, 6.25, 12.5 or 25 percent
// - work range is the range value times 360 over 0xffff, centred on 180 degrees
`timescale 1ns/100ps
`default_nettype none
module aod_top #(
  parameter int          MS_CYCLES     = aod_pkg::MS_CYCLES,
  parameter logic [31:0] FACTORY_TRACE = 32'h0000_0000 // arbitrary value
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // register command port
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_reg,
  output logic             reg_refused_reg,
  output logic             nvm_locked_reg,
  // measurements from the front end
  input  wire logic [15:0] angle_in,
  input  wire logic [4:0]  agc_gain_in,
  input  wire logic [6:0]  temp_in,
  input  wire logic [7:0]  field_in,
  input  wire logic [4:0]  fault_raw_in,
  // results
  output logic      [4:0]  gain_sel_reg,
  output logic      [15:0] out_level_reg,
  output logic      [7:0]  fault_flags_reg,
  output logic             fault_any_reg,
  output logic             diag_active_reg
);
  logic [7:0]  cfg_reg [0:255];
  logic        locked;
  logic        ro_addr;
  logic        wr_ok;
  logic        auto_gain_enable;
  logic        diag_on;
  logic        rot;
  logic [2:0]  fsel;
  logic [1:0]  span;
  logic [15:0] zwp;
  logic [15:0] clo;
  logic [15:0] chi;
  logic [15:0] wrg;
  aod_pkg::aod_lnr_t mode;

  function automatic logic [15:0] w16(input logic [7:0] a);
    w16 = {cfg_reg[8'(a + 8'h01)], cfg_reg[a]};
  endfunction

  assign auto_gain_enable     = cfg_reg[aod_pkg::A_GAIN][aod_pkg::B_AGC];
  assign diag_on = !cfg_reg[aod_pkg::A_DIAG][aod_pkg::B_DDIS];
  assign rot     = cfg_reg[aod_pkg::A_DIAG][aod_pkg::B_ROT];
  assign fsel    = cfg_reg[aod_pkg::A_DIAG][aod_pkg::B_FSEL +: 3];
  assign mode    = aod_pkg::aod_lnr_t'(cfg_reg[aod_pkg::A_DIAG][aod_pkg::B_LNR +: 2]);
  assign span    = cfg_reg[aod_pkg::A_SPAN][1:0];
  assign zwp     = w16(aod_pkg::A_ZWP);
  assign clo     = w16(aod_pkg::A_CLO);
  assign chi     = w16(aod_pkg::A_CHI);
  assign wrg     = w16(aod_pkg::A_WRG);

  // lock is permanent until reset: the lock byte itself is also refused
  assign locked  = cfg_reg[aod_pkg::A_LOCK][aod_pkg::B_LOCK]
                   && (cfg_reg[aod_pkg::A_LOCK][6:0] == aod_pkg::LOCK_KEY);
  assign ro_addr = (reg_addr[7:2] == aod_pkg::A_FTRACE[7:2])
                   || (reg_addr == aod_pkg::A_STATUS) || (reg_addr == aod_pkg::A_GUSE);
  assign wr_ok   = reg_wr_en && !locked && !ro_addr;

  // configuration storage
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 256; i++)
        cfg_reg[i] <= aod_pkg::cfg_reset(8'(i));
    end
    else if (wr_ok)
      cfg_reg[reg_addr] <= reg_wdata;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_refused_reg <= 1'b0;
      nvm_locked_reg  <= 1'b0;
    end
    else
    begin
      reg_refused_reg <= reg_wr_en && !wr_ok;
      nvm_locked_reg  <= locked;
    end
  end

  // register read, one cycle latency
  logic [7:0] rd_val;
  always_comb
  begin
    if (reg_addr[7:2] == aod_pkg::A_FTRACE[7:2])
      rd_val = FACTORY_TRACE[{reg_addr[1:0], 3'h0} +: 8];
    else if (reg_addr == aod_pkg::A_STATUS)
      rd_val = fault_flags_reg;
    else if (reg_addr == aod_pkg::A_GUSE)
      rd_val = {diag_active_reg, locked, 1'b0, gain_sel_reg};
    else
      rd_val = cfg_reg[reg_addr];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata_reg <= 8'h00;
    else if (reg_rd_en)
      reg_rdata_reg <= rd_val;
  end

  // second-stage gain selection
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      gain_sel_reg <= 5'h01;
    else
      gain_sel_reg <= auto_gain_enable ? agc_gain_in : cfg_reg[aod_pkg::A_GAIN][4:0];
  end

  // diagnostic conditions, mask bit 1 suppresses
  logic [7:0] cond;
  logic [7:0] flags;
  assign cond[0] = (temp_in < cfg_reg[aod_pkg::A_TMIN][6:0])
                   || (temp_in > cfg_reg[aod_pkg::A_TMAX][6:0]);
  assign cond[1] = fault_raw_in[0];
  assign cond[2] = (field_in < cfg_reg[aod_pkg::A_FMIN])
                   || (field_in > cfg_reg[aod_pkg::A_FMAX]);
  assign cond[3] = fault_raw_in[1];
  assign cond[4] = fault_raw_in[2];
  assign cond[5] = fault_raw_in[3];
  assign cond[6] = (gain_sel_reg < cfg_reg[aod_pkg::A_GMIN][4:0])
                   || (gain_sel_reg > cfg_reg[aod_pkg::A_GMAX][4:0]);
  assign cond[7] = fault_raw_in[4];

  // shared millisecond tick; one counter instead of eight wide ones
  logic [31:0] ms_cnt_reg;
  logic        tick_reg;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ms_cnt_reg <= 32'h0;
      tick_reg   <= 1'b0;
    end
    else
    begin
      tick_reg   <= (ms_cnt_reg == 32'(MS_CYCLES - 1));
      ms_cnt_reg <= (ms_cnt_reg == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt_reg + 32'h1;
    end
  end

  for (genvar g = 0; g < 8; g++)
  begin : g_flt
    aod_flt_if ch ();
    assign ch.tick  = tick_reg;
    assign ch.raw   = cond[g] && !cfg_reg[aod_pkg::A_MASK][g] && diag_on;
    assign ch.up_ms = aod_pkg::UP_MS[{fsel, 3'h0} +: 8];
    assign ch.dn_ms = aod_pkg::DN_MS[{fsel, 3'h0} +: 8];
    assign flags[g] = ch.flag;
    aod_debounce u_deb (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .f       (ch.filt)
    );
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_flags_reg <= 8'h00;
      fault_any_reg   <= 1'b0;
      diag_active_reg <= 1'b0;
    end
    else
    begin
      fault_flags_reg <= diag_on ? flags : 8'h00;
      fault_any_reg   <= diag_on && (flags != 8'h00);
      diag_active_reg <= diag_on;
    end
  end

  // output shaping
  logic [15:0] ang;
  assign ang = 16'((rot ? 16'(-angle_in) : angle_in) - zwp);

  function automatic logic signed [19:0] ycv(input aod_pkg::aod_lnr_t m, input logic [15:0] v);
    unique case (m)
      aod_pkg::LNR_4PT:  ycv = {{3{v[15]}}, v, 1'b0};
      aod_pkg::LNR_8PT:  ycv = {4'h0, v};
      aod_pkg::LNR_16PT: ycv = {3'h0, v, 1'b0} - 20'h08000;
      aod_pkg::LNR_32PT: ycv = {4'h0, v};
    endcase
  endfunction

  // ideal line plus scaled signed offset; the end point carries no offset
  function automatic logic signed [19:0] y32(input logic [5:0] i, input logic [1:0] sp);
    logic signed [19:0] d;
    d = 20'(signed'(cfg_reg[8'(aod_pkg::A_DY + {2'h0, i})]));
    d = d <<< (aod_pkg::DY_SHIFT + int'(sp));
    y32 = {3'h0, i, 11'h000} + ((i[5]) ? 20'sh0 : d);
  endfunction

  function automatic logic [15:0] px(input logic [3:0] k);
    px = (k == 4'h0) ? 16'h0 : w16(8'(aod_pkg::A_PX + {3'h0, 4'(k - 4'h1), 1'b0}));
  endfunction

  function automatic logic [15:0] py(input logic [4:0] k);
    py = w16(8'(aod_pkg::A_PY + {2'h0, k, 1'b0}));
  endfunction

  logic [3:0]         np;
  logic [3:0]         seg;
  logic [15:0]        x0;
  logic [15:0]        x1;
  logic signed [19:0] ya;
  logic signed [19:0] yb;
  logic signed [19:0] sl;
  logic signed [19:0] yi;
  logic [20:0]        tn;
  logic [20:0]        td;
  logic               usr;
  logic [16:0]        lo;
  logic [20:0]        pos;
  logic [5:0]         nseg;
  logic [5:0]         idx;
  logic signed [41:0] prod;
  logic [15:0]        yc;

  always_comb
  begin
    np   = (mode == aod_pkg::LNR_4PT) ? 4'h4 : 4'h8;
    seg  = 4'h0;
    x0   = 16'h0;
    x1   = 16'h0;
    ya   = 20'sh0;
    yb   = 20'sh0;
    sl   = 20'sh0;
    tn   = 21'h0;
    td   = 21'h0;
    usr  = (mode == aod_pkg::LNR_4PT);
    nseg = (mode == aod_pkg::LNR_16PT) ? 6'h10 : 6'h20;
    lo   = aod_pkg::MID_ANGLE - {2'h0, wrg[15:1]};
    pos  = 21'h0;
    idx  = 6'h0;
    if (mode == aod_pkg::LNR_4PT || mode == aod_pkg::LNR_8PT)
    begin
      // points assumed in rising X order
      for (int k = 1; k <= 8; k++)
        if (4'(k) <= np && ang >= px(4'(k)))
          seg = 4'(k);
      x0 = px(seg);
      ya = (seg == 4'h0 && mode == aod_pkg::LNR_8PT) ? 20'sh0 : ycv(mode, py(5'(seg)));
      if (seg < np)
      begin
        x1 = px(4'(seg + 4'h1));
        yb = ycv(mode, py(5'(seg + 4'h1)));
      end
      else
      begin
        x1 = x0;
        yb = ya;
      end
      sl = 20'(signed'(w16(8'(aod_pkg::A_SLOPE + {3'h0, seg, 1'b0}))));
      tn = {5'h0, 16'(ang - x0)};
      td = {5'h0, 16'(x1 - x0)};
    end
    else
    begin
      // equal spacing: position scaled by segment count, then divided by range
      if ({1'b0, ang} >= lo)
        pos = 21'({4'h0, 17'({1'b0, ang} - lo)} << ((mode == aod_pkg::LNR_16PT) ? 4 : 5));
      // a far-out angle with a narrow range would otherwise wrap the 6-bit index
      idx = (wrg == 16'h0 || pos >= 21'(nseg) * {5'h0, wrg}) ? nseg : 6'(pos / {5'h0, wrg});
      if (idx >= nseg)
      begin
        idx = nseg;
        tn  = 21'h0;
      end
      else
        tn = 21'(pos - 21'(idx * wrg));
      td = {5'h0, wrg};
      if (mode == aod_pkg::LNR_16PT)
      begin
        ya = ycv(mode, py(5'(idx)));
        yb = (idx == nseg) ? ya : ycv(mode, py(5'(idx + 6'h1)));
      end
      else
      begin
        ya = y32(idx, span);
        yb = (idx == nseg) ? ya : y32(6'(idx + 6'h1), span);
      end
    end
    // slope in 1/256 output step per angle step
    if (usr)
      prod = 42'((sl * signed'({1'b0, tn})) >>> 8);
    else if (td == 21'h0)
      prod = 42'sh0;
    else
      prod = 42'(((yb - ya) * signed'({1'b0, tn})) / signed'({1'b0, td}));
    yi = 20'(ya + 20'(prod));
    if (yi < signed'({4'h0, clo}))
      yc = clo;
    else if (yi > signed'({4'h0, chi}))
      yc = chi;
    else
      yc = yi[15:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      out_level_reg <= 16'h0;
    else
      out_level_reg <= yc;
  end
endmodule
`default_nettype wire

// File: verif/aod_host.sv
`timescale 1ns/100ps
`default_nettype none
module aod_host (
  // clock
  input  wire logic       sys_clk,
  // register command port
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_reg,
  input  wire logic       reg_refused_reg
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // idle bus shows inverted values so stale data is never mistaken for a hold
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic refused);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1 refused = reg_refused_reg;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    logic r;
    wr(a, d[7:0], r);
    wr(a + 8'h01, d[15:8], r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1 d = reg_rdata_reg;
  endtask
endmodule
`default_nettype wire

// File: verif/aod_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module aod_top_sva #(
  parameter int MS_CYCLES = 10
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // register port
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_refused_reg,
  input wire logic       nvm_locked_reg,
  // diagnostics
  input wire logic [7:0] fault_flags_reg,
  input wire logic       fault_any_reg,
  input wire logic       diag_active_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // cycles since the converter flag last moved
  logic adc_prev_reg;
  int   gap_reg;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      adc_prev_reg <= 1'b0;
      gap_reg      <= 0;
    end
    else
    begin
      adc_prev_reg <= fault_flags_reg[1];
      gap_reg      <= (fault_flags_reg[1] != adc_prev_reg) ? 0 : gap_reg + 1;
    end
  end

  sequence lock_wr_s;
    reg_wr_en && reg_addr == aod_pkg::A_LOCK && !nvm_locked_reg;
  endsequence
  sequence key_wr_s;
    lock_wr_s ##0 reg_wdata == {1'b1, aod_pkg::LOCK_KEY};
  endsequence
  sequence miss_wr_s;
    lock_wr_s ##0 reg_wdata != {1'b1, aod_pkg::LOCK_KEY};
  endsequence

  lock_arm_a: assert property (key_wr_s |-> ##[1:2] nvm_locked_reg)
    else $error("key write did not lock");
  lock_miss_a: assert property (miss_wr_s |=> !nvm_locked_reg [*2])
    else $error("lock taken without key");
  lock_hold_a: assert property (nvm_locked_reg |=> nvm_locked_reg)
    else $error("lock released without reset");
  lock_refuse_a: assert property (reg_wr_en && nvm_locked_reg |=> reg_refused_reg)
    else $error("write accepted while locked");
  trace_ro_a: assert property (reg_wr_en && reg_addr[7:2] == 6'h05 |=> reg_refused_reg)
    else $error("factory byte write accepted");
  tag_write_a: assert property (reg_wr_en && !nvm_locked_reg
                                && reg_addr[7:2] == 6'h06 |=> !reg_refused_reg)
    else $error("user tag write refused");
  no_refuse_a: assert property (!reg_wr_en |=> !reg_refused_reg)
    else $error("refusal without a write");
  diag_off_a: assert property (!diag_active_reg [*2] |-> fault_flags_reg == 8'h00 && !fault_any_reg)
    else $error("flags while diagnostics off");
  any_flag_a: assert property ($rose(fault_any_reg) |-> fault_flags_reg != 8'h00 && diag_active_reg)
    else $error("summary without flag");
  flag_hold_a: assert property ($fell(fault_flags_reg[1]) && diag_active_reg
                                |-> gap_reg >= 20 * MS_CYCLES - 2)
    else $error("flag cleared too early");
endmodule

bind aod_top aod_top_sva #(.MS_CYCLES(MS_CYCLES)) chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_refused_reg(reg_refused_reg), .nvm_locked_reg(nvm_locked_reg),
  .fault_flags_reg(fault_flags_reg), .fault_any_reg(fault_any_reg), .diag_active_reg(diag_active_reg));
`default_nettype wire

// File: verif/tb_angle_output_config_diag.sv
`timescale 1ns/100ps
`default_nettype none
module tb_angle_output_config_diag;
  localparam int          MSC   = 10;
  localparam logic [31:0] TRACE = 32'h5a3c_c3a5; // arbitrary value
  logic        sys_clk, reset_n, reg_wr_en, reg_rd_en, rf;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_reg, rv, fault_flags_reg, field_in;
  logic        reg_refused_reg, nvm_locked_reg, fault_any_reg, diag_active_reg;
  logic [15:0] angle_in, out_level_reg;
  logic [4:0]  agc_gain_in, fault_raw_in, gain_sel_reg;
  logic [6:0]  temp_in;
  int          failures, total_checks;
  int          up_ms [8] = '{20, 20, 20, 40, 60, 80, 100, 120};
  int          dn_ms [8] = '{20, 30, 40, 40, 80, 100, 120, 140};
  int          pos   [5] = '{1, 3, 4, 5, 7};

  aod_top #(.MS_CYCLES(MSC), .FACTORY_TRACE(TRACE)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg), .reg_refused_reg(reg_refused_reg), .nvm_locked_reg(nvm_locked_reg),
    .angle_in(angle_in), .agc_gain_in(agc_gain_in), .temp_in(temp_in), .field_in(field_in),
    .fault_raw_in(fault_raw_in), .gain_sel_reg(gain_sel_reg), .out_level_reg(out_level_reg),
    .fault_flags_reg(fault_flags_reg), .fault_any_reg(fault_any_reg), .diag_active_reg(diag_active_reg));
  aod_host host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg), .reg_refused_reg(reg_refused_reg));

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // curve arithmetic rounds, so allow a small band around the ideal line
  task automatic near(input logic [15:0] e);
    check({15'h0, out_level_reg + 16'h0040 - e <= 16'h0080}, 16'h0001);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_flag(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (fault_flags_reg[b] !== v && n < 2000)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    check({15'h0, n >= lim * MSC - 1 && n <= (lim + 1) * MSC + 4}, 16'h0001);
  endtask
  task automatic thr(input logic [7:0] a, input logic [7:0] v, input int b, input logic [7:0] d);
    host.wr(a, v, rf);
    wait_flag(b, 1'b1, 20);
    host.wr(a, d, rf);
    wait_flag(b, 1'b0, 20);
  endtask

  task automatic t_reset();
    check(gain_sel_reg, agc_gain_in);
    check(diag_active_reg, 1'b0);
    host.rd(aod_pkg::A_MASK, rv);
    check(rv, 8'h80);
  endtask
  task automatic t_gain();
    host.wr(aod_pkg::A_GAIN, 8'h0c, rf);
    @(posedge sys_clk);
    agc_gain_in <= 5'h07;
    pause(2);
    check(gain_sel_reg, 5'h0c);
    host.wr(aod_pkg::A_GAIN, 8'h81, rf);
    pause(1);
    check(gain_sel_reg, 5'h07);
  endtask
  task automatic t_ids();
    for (int k = 0; k < 4; k++)
    begin
      host.wr(aod_pkg::A_UTAG + 8'(k), 8'hff ^ 8'(k * 8'h5a), rf);
      check(rf, 1'b0);
      host.rd(aod_pkg::A_UTAG + 8'(k), rv);
      check(rv, 8'hff ^ 8'(k * 8'h5a));
      host.wr(aod_pkg::A_FTRACE + 8'(k), 8'h00, rf);
      check(rf, 1'b1);
      host.rd(aod_pkg::A_FTRACE + 8'(k), rv);
      check(rv, TRACE[8*k +: 8]);
    end
  endtask
  task automatic t_diag();
    host.wr(aod_pkg::A_MASK, 8'h00, rf);
    for (int s = 0; s < 8; s++)
    begin
      host.wr(aod_pkg::A_DIAG, 8'h30 | 8'(s << 1), rf);
      @(posedge sys_clk);
      fault_raw_in <= 5'h01;
      wait_flag(1, 1'b1, up_ms[s]);
      check({diag_active_reg, fault_any_reg}, 2'b11);
      @(posedge sys_clk);
      fault_raw_in <= 5'h00;
      wait_flag(1, 1'b0, dn_ms[s]);
    end
    host.wr(aod_pkg::A_DIAG, 8'h30, rf);
    for (int b = 0; b < 5; b++)
    begin
      @(posedge sys_clk);
      fault_raw_in <= 5'h01 << b;
      wait_flag(pos[b], 1'b1, 20);
      @(posedge sys_clk);
      fault_raw_in <= 5'h00;
      wait_flag(pos[b], 1'b0, 20);
    end
    thr(aod_pkg::A_TMAX, 8'h10, 0, 8'h7f);
    thr(aod_pkg::A_TMIN, 8'h30, 0, 8'h00);
    thr(aod_pkg::A_FMIN, 8'h40, 2, 8'h00);
    thr(aod_pkg::A_FMAX, 8'h08, 2, 8'hff);
    thr(aod_pkg::A_GMIN, 8'h10, 6, 8'h00);
    thr(aod_pkg::A_GMAX, 8'h03, 6, 8'h1f);
    host.wr(aod_pkg::A_MASK, 8'h02, rf);
    @(posedge sys_clk);
    fault_raw_in <= 5'h01;
    pause(400);
    check(fault_flags_reg, 8'h00);
    host.wr(aod_pkg::A_MASK, 8'h00, rf);
    wait_flag(1, 1'b1, 20);
    host.wr(aod_pkg::A_DIAG, 8'h31, rf);
    pause(2);
    check({diag_active_reg, fault_flags_reg}, 9'h000);
  endtask
  task automatic t_out();
    @(posedge sys_clk);
    angle_in <= 16'h4000;
    pause(2);
    near(16'h4000);
    host.wr(aod_pkg::A_DIAG, 8'h71, rf);
    pause(2);
    near(16'hc000);
    host.wr(aod_pkg::A_DIAG, 8'h31, rf);
    host.wr16(aod_pkg::A_ZWP, 16'h2000);
    pause(2);
    near(16'h2000);
    host.wr16(aod_pkg::A_ZWP, 16'h0000);
    host.wr16(aod_pkg::A_WRG, 16'h8000);
    @(posedge sys_clk);
    angle_in <= 16'ha000;
    pause(2);
    near(16'hc000);
    @(posedge sys_clk);
    angle_in <= 16'h8000;
    host.wr(aod_pkg::A_DY + 8'h10, 8'h7f, rf);
    for (int s = 0; s < 4; s++)
    begin
      host.wr(aod_pkg::A_SPAN, 8'(s), rf);
      pause(2);
      near(16'h8000 + (16'h007f << (4 + s)));
    end
    host.wr16(aod_pkg::A_CLO, 16'h3000);
    host.wr16(aod_pkg::A_CHI, 16'h9000);
    pause(2);
    check(out_level_reg, 16'h9000);
    for (int m = 0; m < 3; m++)
    begin
      host.wr(aod_pkg::A_DIAG, 8'h01 | 8'(m << 4), rf);
      pause(2);
      check(out_level_reg, 16'h3000);
    end
    for (int k = 0; k < 17; k++)
      host.wr16(aod_pkg::A_PY + 8'(2 * k), 16'hffff);
    pause(2);
    check(out_level_reg, 16'h9000);
  endtask
  task automatic t_curve();
    host.wr16(aod_pkg::A_CLO, 16'h0000);
    host.wr16(aod_pkg::A_CHI, 16'hffff);
    for (int k = 0; k < 8; k++)
      host.wr16(aod_pkg::A_PX + 8'(2 * k), 16'(16'h2000 * (k + 1) - 1));
    host.wr(aod_pkg::A_DIAG, 8'h11, rf);
    @(posedge sys_clk);
    angle_in <= 16'h1000;
    pause(2);
    near(16'h8000);
    host.wr16(aod_pkg::A_PY, 16'h0000);
    host.wr16(aod_pkg::A_SLOPE, 16'h0400);
    host.wr(aod_pkg::A_DIAG, 8'h01, rf);
    pause(2);
    near(16'h4000);
  endtask
  task automatic t_lock();
    host.wr(aod_pkg::A_LOCK, 8'hb9, rf);
    host.wr(aod_pkg::A_LOCK, 8'h3a, rf);
    pause(1);
    check(nvm_locked_reg, 1'b0);
    host.wr(aod_pkg::A_LOCK, 8'hba, rf);
    pause(1);
    check(nvm_locked_reg, 1'b1);
    host.wr(aod_pkg::A_UTAG, 8'h11, rf);
    check(rf, 1'b1);
    host.rd(aod_pkg::A_UTAG, rv);
    check(rv, 8'hff);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    pause(2);
    host.rd(aod_pkg::A_UTAG, rv);
    check({nvm_locked_reg, rv}, 9'h000);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    failures = 0;
    total_checks = 0;
    reset_n = 1'b0;
    angle_in = 16'h0000;
    agc_gain_in = 5'h03;
    temp_in = 7'h20;
    field_in = 8'h10;
    fault_raw_in = 5'h00;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    pause(2);
    t_reset();
    t_gain();
    t_ids();
    t_diag();
    t_out();
    t_curve();
    t_lock();
    finish_test();
  end

  // about three times the expected run length
  initial
  begin
    #200000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
